// >>> bench/stm_peer.sv
/*
  Link partner: a slave that answers the engine's clock, and a master task
  that clocks the engine. Assumes the bench resolves the shared pins.
*/
`timescale 1ns/1ns
`default_nettype none
module stm_peer (
  // Line levels seen by the partner
  input wire logic sck_line,
  input wire logic mosi_line,
  input wire logic miso_line,
  input wire logic cpol,
  // Partner drives
  output logic sck_drv,
  output logic nss_n,
  output logic mosi_drv,
  output logic miso_drv
);
  logic [15:0] tx = 16'h0000; // Slave send word, next bit on top
  logic [15:0] rx = 16'h0000; // Master-out bits, newest lowest
  logic [15:0] mrx = 16'h0000; // Slave-out bits seen while mastering
  logic e; // Rises on the sampling edge, first-edge phase only
  initial begin
    sck_drv = 1'h0;
    nss_n = 1'h1;
    mosi_drv = 1'h0;
  end
  assign e = sck_line ^ cpol;
  // Slave side samples on the leading edge
  always @(posedge e) rx <= {rx[14:0], mosi_line};
  // Trailing edge moves on; spent bits return inverted so stale data never matches
  always @(negedge e) tx <= {tx[14:0], ~tx[15]};
  assign miso_drv = tx[15];
  // Master side: select, clock n bits at 64 ns with the clock idle low, release
  task automatic drive(input logic [15:0] w, input int n);
    nss_n = 1'h0;
    mosi_drv = w[15];
    #64;
    for (int i = 0; i < n; i++) begin
      sck_drv = 1'h1;
      mrx = {mrx[14:0], miso_line};
      #32;
      sck_drv = 1'h0;
      w = {w[14:0], 1'h0};
      mosi_drv = w[15];
      #32;
    end
    nss_n = 1'h1;
    mosi_drv = ~mosi_drv;
  endtask : drive
endmodule : stm_peer
`default_nettype wire

// >>> bench/stm_spi_engine_properties.sv
/*
  Checker for the serial transfer engine: flag, interrupt and pin relations.
  Assumes it is bound to the engine's top module and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module stm_spi_engine_properties #(
  parameter int FW = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Mode and interrupt controls
  input wire logic module_enable,
  input wire logic master_select,
  input wire logic one_wire_mode,
  input wire logic one_wire_output_enable,
  input wire logic receive_only,
  input wire logic clock_polarity,
  input wire logic transmit_empty_irq_enable,
  input wire logic receive_not_empty_irq_enable,
  // Data access
  input wire logic data_wr_strobe,
  input wire logic data_rd_strobe,
  input wire logic [FW-1:0] data_rd,
  // Flags and pins driven by the engine
  input wire logic transmit_empty_flag,
  input wire logic receive_not_empty_flag,
  input wire logic busy_flag,
  input wire logic transmit_empty_irq,
  input wire logic receive_not_empty_irq,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n
);
  // One clock domain, so clock and reset are given once
  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);

  wr_clears_te_a: assert property (data_wr_strobe |=> !transmit_empty_flag)
    else $error("transmit empty flag stayed set after a write");
  // A word landing with the read is kept, so a changed buffer excuses the flag
  rd_clears_rne_a: assert property (
    data_rd_strobe |=> !receive_not_empty_flag || $changed(data_rd))
    else $error("receive flag stayed set after a read");
  te_irq_a: assert property (
    !$past(srst) |-> transmit_empty_irq == $past(transmit_empty_flag && transmit_empty_irq_enable))
    else $error("transmit empty request does not follow flag and enable");
  rne_irq_a: assert property (
    !$past(srst) |-> receive_not_empty_irq ==
      $past(receive_not_empty_flag && receive_not_empty_irq_enable))
    else $error("receive request does not follow flag and enable");
  keep_unread_a: assert property (
    receive_not_empty_flag && !data_rd_strobe |=> $stable(data_rd))
    else $error("unread word overwritten");
  // Pin lags the internal clock by one cycle, hence two idle cycles
  idle_level_a: assert property (
    !sck_oe_n && !one_wire_mode && !receive_only && !busy_flag && !$past(busy_flag)
    && $stable(clock_polarity) |-> sck_out == clock_polarity)
    else $error("serial clock not at idle level");
  clock_drive_a: assert property (
    $stable(module_enable && master_select) |-> sck_oe_n == !(module_enable && master_select))
    else $error("serial clock drive does not match master enable");
  no_drive_rx_a: assert property (
    one_wire_mode && !one_wire_output_enable && $past(one_wire_mode && !one_wire_output_enable)
    |-> mosi_oe_n && miso_oe_n)
    else $error("data pin driven in one-wire receive");
  rx_busy_a: assert property (
    (module_enable && master_select && receive_only && !one_wire_mode)[*5] |-> busy_flag)
    else $error("busy low during master receive-only");
endmodule : stm_spi_engine_properties

bind stm_spi_engine stm_spi_engine_properties #(.FW(FW)) stm_spi_engine_properties_i (
  .mclk(mclk), .srst(srst), .module_enable(module_enable), .master_select(master_select),
  .one_wire_mode(one_wire_mode), .one_wire_output_enable(one_wire_output_enable),
  .receive_only(receive_only), .clock_polarity(clock_polarity),
  .transmit_empty_irq_enable(transmit_empty_irq_enable),
  .receive_not_empty_irq_enable(receive_not_empty_irq_enable),
  .data_wr_strobe(data_wr_strobe), .data_rd_strobe(data_rd_strobe), .data_rd(data_rd),
  .transmit_empty_flag(transmit_empty_flag), .receive_not_empty_flag(receive_not_empty_flag),
  .busy_flag(busy_flag), .transmit_empty_irq(transmit_empty_irq),
  .receive_not_empty_irq(receive_not_empty_irq), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
  .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n)
);
`default_nettype wire

// >>> bench/testbench.sv
/*
  Self-checking bench for the serial transfer engine and its link partner.
  Assumes the partner model and the bound checker are compiled with it.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // Engine inputs, all valued at time zero
  logic mclk = 1'h0, srst = 1'h1, module_enable = 1'h0, master_select = 1'h0;
  logic one_wire_mode = 1'h0, one_wire_output_enable = 1'h0, receive_only = 1'h0;
  logic clock_polarity = 1'h0, clock_phase = 1'h0, frame_width_select = 1'h0;
  logic lsb_first_select = 1'h0, data_wr_strobe = 1'h0, data_rd_strobe = 1'h0;
  logic transmit_empty_irq_enable = 1'h1, receive_not_empty_irq_enable = 1'h1;
  logic status_rd_strobe = 1'h0;
  logic [2:0] baud_rate_select = 3'h0;
  logic [15:0] data_wr = 16'h0000;
  // Engine outputs
  logic [15:0] data_rd;
  logic transmit_empty_flag, receive_not_empty_flag, overflow_flag, busy_flag;
  logic transmit_empty_irq, receive_not_empty_irq, sck_out, sck_oe_n;
  logic mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  // Resolved pins and partner drives
  logic sck_line, mosi_line, miso_line, p_sck, p_nss_n, p_mosi, p_miso;
  int fail_count = 0;
  int total_checks = 0;
  // Each shared pin carries whoever has its enable low
  assign sck_line = !sck_oe_n ? sck_out : p_sck;
  assign mosi_line = !mosi_oe_n ? mosi_out : (master_select ? p_miso : p_mosi);
  assign miso_line = !miso_oe_n ? miso_out : p_miso;
  initial forever #4 mclk = ~mclk;

  stm_spi_engine #(.FW(16)) stm_spi_engine_i (
    .mclk(mclk), .srst(srst), .module_enable(module_enable), .master_select(master_select),
    .one_wire_mode(one_wire_mode), .one_wire_output_enable(one_wire_output_enable),
    .receive_only(receive_only), .baud_rate_select(baud_rate_select),
    .clock_polarity(clock_polarity), .clock_phase(clock_phase),
    .frame_width_select(frame_width_select), .lsb_first_select(lsb_first_select),
    .transmit_empty_irq_enable(transmit_empty_irq_enable),
    .receive_not_empty_irq_enable(receive_not_empty_irq_enable),
    .data_wr_strobe(data_wr_strobe), .data_wr(data_wr), .data_rd_strobe(data_rd_strobe),
    .data_rd(data_rd), .status_rd_strobe(status_rd_strobe),
    .transmit_empty_flag(transmit_empty_flag), .receive_not_empty_flag(receive_not_empty_flag),
    .overflow_flag(overflow_flag), .busy_flag(busy_flag),
    .transmit_empty_irq(transmit_empty_irq), .receive_not_empty_irq(receive_not_empty_irq),
    .sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .slave_select_n(p_nss_n),
    .mosi_in(mosi_line), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_in(miso_line), .miso_out(miso_out), .miso_oe_n(miso_oe_n)
  );
  stm_peer stm_peer_i (
    .sck_line(sck_line), .mosi_line(mosi_line), .miso_line(miso_line),
    .cpol(clock_polarity), .sck_drv(p_sck), .nss_n(p_nss_n), .mosi_drv(p_mosi),
    .miso_drv(p_miso)
  );

  // Inputs change one nanosecond after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse_wr(input logic [15:0] w);
    data_wr = w;
    data_wr_strobe = 1'h1;
    tick(1);
    data_wr_strobe = 1'h0;
  endtask : pulse_wr
  task automatic pulse_rd;
    data_rd_strobe = 1'h1;
    tick(1);
    data_rd_strobe = 1'h0;
  endtask : pulse_rd
  // Bounded wait for a flag level, then a cycle for lagging pins; a timeout mismatches
  task automatic wait_for(ref logic f, input logic lvl);
    int n;
    n = 0;
    while (f !== lvl && n < 3000) begin
      tick(1);
      n++;
    end
    chk(16'(f), 16'(lvl));
    tick(1);
  endtask : wait_for
  // Reconfigure only while disabled; a stale received word is read away
  task automatic setup(input logic ms, ow, ro, w16, lsb, pol, input logic [2:0] br);
    module_enable = 1'h0;
    tick(2);
    pulse_rd;
    master_select = ms;
    one_wire_mode = ow;
    receive_only = ro;
    frame_width_select = w16;
    lsb_first_select = lsb;
    clock_polarity = pol;
    baud_rate_select = br;
    tick(2);
    module_enable = 1'h1;
    tick(2);
  endtask : setup

  // Master full duplex, 8-bit, MSB first
  task automatic t_duplex;
    setup(1, 0, 0, 0, 0, 0, 3'h2);
    stm_peer_i.tx = 16'h3C00;
    pulse_wr(16'h00A5);
    wait_for(receive_not_empty_flag, 1'h1);
    chk(data_rd, 16'h003C);
    chk({8'h00, stm_peer_i.rx[7:0]}, 16'h00A5);
    pulse_rd;
    chk(16'(receive_not_empty_flag), 16'h0000);
    wait_for(busy_flag, 1'h0);
  endtask : t_duplex
  // 16-bit LSB first, idle high, second word queued while the first runs
  task automatic t_stream;
    setup(1, 0, 0, 1, 1, 1, 3'h2);
    stm_peer_i.tx = 16'hC0DE;
    pulse_wr(16'h1234);
    wait_for(transmit_empty_flag, 1'h1);
    pulse_wr(16'hBEEF);
    wait_for(receive_not_empty_flag, 1'h1);
    chk(data_rd, 16'h7B03);
    chk(16'(busy_flag), 16'h0001);
    chk(stm_peer_i.rx, 16'h2C48);
    pulse_rd;
    wait_for(receive_not_empty_flag, 1'h1);
    chk(data_rd, 16'h84FC);
    chk(stm_peer_i.rx, 16'hF77D);
    wait_for(busy_flag, 1'h0);
  endtask : t_stream
  // Master receive-only: runs from enable, overflow keeps the unread word
  task automatic t_rx_only;
    setup(1, 0, 1, 0, 0, 0, 3'h3);
    stm_peer_i.tx = 16'h6900;
    wait_for(receive_not_empty_flag, 1'h1);
    chk(data_rd, 16'h0069);
    chk(16'(busy_flag), 16'h0001);
    wait_for(overflow_flag, 1'h1);
    chk(data_rd, 16'h0069);
    pulse_rd;
    status_rd_strobe = 1'h1;
    tick(1);
    status_rd_strobe = 1'h0;
    chk(16'(overflow_flag), 16'h0000);
  endtask : t_rx_only
  // Master one-wire receive: clock from enable, no data pin driven
  task automatic t_one_wire;
    transmit_empty_irq_enable = 1'h0;
    setup(1, 1, 0, 0, 0, 0, 3'h2);
    stm_peer_i.tx = 16'hA700;
    wait_for(receive_not_empty_flag, 1'h1);
    chk(data_rd, 16'h00A7);
    chk({14'h0000, mosi_oe_n, miso_oe_n}, 16'h0003);
  endtask : t_one_wire
  // Slave full duplex, then two-wire receive-only, clocked by the partner
  task automatic t_slave;
    receive_not_empty_irq_enable = 1'h0;
    setup(0, 0, 0, 0, 0, 0, 3'h7);
    pulse_wr(16'h005A);
    tick(8);
    stm_peer_i.drive(16'hC300, 8);
    wait_for(receive_not_empty_flag, 1'h1);
    chk(data_rd, 16'h00C3);
    chk({8'h00, stm_peer_i.mrx[7:0]}, 16'h005A);
    setup(0, 0, 1, 0, 0, 0, 3'h0);
    stm_peer_i.drive(16'h9600, 8);
    wait_for(receive_not_empty_flag, 1'h1);
    chk(data_rd, 16'h0096);
    chk(16'(miso_oe_n), 16'h0001);
  endtask : t_slave

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // Main sequence: reset for ten cycles, then each scenario
  initial begin
    tick(10);
    srst = 1'h0;
    tick(1);
    t_duplex;
    t_stream;
    t_rx_only;
    t_one_wire;
    t_slave;
    print_verdict;
  end
  // Hang guard: the scenarios need a few thousand cycles at most
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end
endmodule : testbench
`default_nettype wire

// >>> common/stm_consts.svh
/*
  Constants for the serial transfer engine: frame edge counts, divider
  width, reset values. Assumes it is included by bare name.
*/
`ifndef STM_CONSTS_SVH
`define STM_CONSTS_SVH

// Widest frame in bits
`define STM_FRAME_MAX 16
// Index of the last clock edge of a frame, per frame width
`define STM_LAST_EDGE_8 5'h0F
`define STM_LAST_EDGE_16 5'h1F
// Width of the baud divider counter
`define STM_DIV_W 8
// Reset value of the transmit-empty flag
`define STM_TE_RESET 1'h1

`endif

// >>> common/stm_pkg.sv
/*
  Types for the serial transfer engine.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package stm_pkg;
  // Engine state: idle between frames, run while a frame is clocked
  typedef enum logic {
    STM_IDLE,
    STM_RUN
  } stm_state_t;
endpackage : stm_pkg
`default_nettype wire

// >>> logic/stm_spi_engine.sv
/*
  Serial peripheral transfer engine: master and slave, full duplex,
  two-wire receive-only and one-wire send/receive, with transmit-empty,
  receive-not-empty, overflow and busy flags.
  Assumes a single 125 MHz clock mclk with synchronous reset srst; all
  link pins are asynchronous and are synchronised here. Software access
  is by plain strobes and control bits, no register bus.
*/
// Contract
// RL1: Master receive-only clocks continuously while enabled.
// RL2: Slave receive-only receives while selected and clocked.
// RL3: Data read clears receive-not-empty flag.
// RL4: Four control bits select the operating mode.
// RL5: Master one-wire send: write starts, no receive.
// RL6: Master one-wire receive starts on enable, no drive.
// RL7: Slave full duplex starts on first clock edge.
// RL8: Slave software loads data before master clocks.
// RL9: Slave two-wire receive starts with clock and data.
// RL10: Slave one-wire send starts at first edge.
// RL11: Slave one-wire receive: no drive, shift in.
// RL12: Baud select sets master clock; slave ignores.
// RL13: Frame bit selects 8 or 16 bit frames.
// RL14: Buffer to shifter sets transmit-empty; write clears.
// RL15: Last sample edge stores word, sets not-empty.
// RL16: Master starts on write; early write continues seamlessly.
// RL17: Selected slave sends from first incoming edge.
// RL18: Slave enabled and loaded before master clocks.
// RL19: Master continuous: clock unbroken, busy stays set.
// RL20: Late next word: busy drops between words.
// RL21: Master receive-only keeps clock running, busy high.
// RL22: Slave busy drops one clock between words.
// RL23: Polarity sets idle level, phase sets sample edge.
// RL24: Bit-order control: zero MSB first, one LSB.
// RL25: Word while not-empty set: overflow, new discarded.
// RL26: Sixteen-bit frames use sixteen-bit paths and edges.
`timescale 1ns/1ns
`default_nettype none
`include "stm_consts.svh"

module stm_spi_engine
  import stm_pkg::*;
#(
  parameter int FW = `STM_FRAME_MAX
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Mode and format control
  input wire logic module_enable,
  input wire logic master_select,
  input wire logic one_wire_mode,
  input wire logic one_wire_output_enable,
  input wire logic receive_only,
  input wire logic [2:0] baud_rate_select,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic frame_width_select,
  input wire logic lsb_first_select,
  input wire logic transmit_empty_irq_enable,
  input wire logic receive_not_empty_irq_enable,
  // Data register access
  input wire logic data_wr_strobe,
  input wire logic [FW-1:0] data_wr,
  input wire logic data_rd_strobe,
  output logic [FW-1:0] data_rd,
  input wire logic status_rd_strobe,
  // Status and interrupt requests
  output logic transmit_empty_flag,
  output logic receive_not_empty_flag,
  output logic overflow_flag,
  output logic busy_flag,
  output logic transmit_empty_irq,
  output logic receive_not_empty_irq,
  // Link pins, enables active low
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic slave_select_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n
);

  // Outgoing bit from the transmit shifter for the chosen order/width
  function automatic logic out_bit(input logic [FW-1:0] sh, input logic lsb,
                                   input logic wide);
    if (lsb) begin
      out_bit = sh[0];
    end else if (wide) begin
      out_bit = sh[FW-1];
    end else begin
      out_bit = sh[FW/2-1];
    end
  endfunction : out_bit

  // Receive shifter after one more bit enters it
  function automatic logic [FW-1:0] rx_step(input logic [FW-1:0] sh,
                                            input logic b, input logic lsb);
    if (lsb) begin
      rx_step = {b, sh[FW-1:1]};
    end else begin
      rx_step = {sh[FW-2:0], b};
    end
  endfunction : rx_step

  // Synchroniser stages; stage one is read only by stage two
  logic sck_s1, sck_s2, sck_s3;
  logic ss_s1, ss_s2;
  logic mo_s1, mo_s2;
  logic mi_s1, mi_s2;

  // Engine state
  stm_state_t state;
  logic [4:0] edge_cnt;                  // Edge index within the frame
  logic [`STM_DIV_W-1:0] div_cnt;        // Half-period divider
  logic sck_q;                           // Internal serial clock level
  logic [FW-1:0] tx_buf;                 // Send buffer
  logic tx_full;                         // Send buffer holds a word
  logic [FW-1:0] tx_shift;               // Outgoing shifter
  logic shift_loaded;                    // Slave shifter preloaded
  logic [FW-1:0] rx_shift;               // Incoming shifter
  logic ovf_armed;                       // Data read seen while overflowed

  // Derived decode
  logic is_master, rx_mode, tx_mode, rx_store;
  logic [4:0] last_edge, last_sample;
  logic [`STM_DIV_W-1:0] div_last;
  logic tick, m_edge, s_edge, any_edge;
  logic sample_edge, shift_edge, done_sample, frame_end;
  logic rx_bit, master_go, load, next_tx_full;
  logic [FW-1:0] rx_full_word, rx_word;

  // Mode decode from the four control bits
  always_comb begin
    is_master = master_select;                                     // RL4
    rx_mode = receive_only | (one_wire_mode & ~one_wire_output_enable); // RL4
    tx_mode = ~rx_mode;
    rx_store = ~(one_wire_mode & one_wire_output_enable);          // RL5 RL10
  end

  // Frame length: 8 or 16 bits, two clock edges per bit
  always_comb begin
    last_edge = frame_width_select ? `STM_LAST_EDGE_16 : `STM_LAST_EDGE_8; // RL13 RL26
    last_sample = {last_edge[4:1], clock_phase};                   // RL23
  end

  // Master half-period is 2^baud mclk cycles; a slave ignores it
  always_comb begin
    div_last = `STM_DIV_W'((`STM_DIV_W'(1) << baud_rate_select) - `STM_DIV_W'(1)); // RL12
    tick = is_master & (state == STM_RUN) & (div_cnt == div_last);
    m_edge = tick;
    s_edge = ~is_master & module_enable & ~ss_s2 & (sck_s2 != sck_s3); // RL7 RL17
    any_edge = m_edge | s_edge;
  end

  // Edge classification; phase picks even or odd edges for sampling
  always_comb begin
    sample_edge = any_edge & (edge_cnt[0] == clock_phase);        // RL23
    shift_edge = any_edge & ~sample_edge & (edge_cnt != 5'h00);
    done_sample = sample_edge & (edge_cnt == last_sample);         // RL15
    frame_end = any_edge & (edge_cnt == last_edge);
  end

  // Data input pin: master one-wire uses MOSI, slave one-wire MISO
  always_comb begin
    if (is_master) begin
      rx_bit = one_wire_mode ? mo_s2 : mi_s2;                      // RL6
    end else begin
      rx_bit = one_wire_mode ? mi_s2 : mo_s2;                      // RL9 RL11
    end
  end

  // Completed receive word, justified to the low bits for 8-bit frames
  always_comb begin
    rx_full_word = rx_step(rx_shift, rx_bit, lsb_first_select);    // RL24
    if (frame_width_select) begin
      rx_word = rx_full_word;                                      // RL26
    end else if (lsb_first_select) begin
      rx_word = {{(FW/2){1'b0}}, rx_full_word[FW-1:FW/2]};
    end else begin
      rx_word = {{(FW/2){1'b0}}, rx_full_word[FW/2-1:0]};
    end
  end

  // Start and reload decisions
  always_comb begin
    // Receive modes need no written word to run
    master_go = is_master & module_enable & (rx_mode | tx_full);   // RL1 RL6 RL16
    if (is_master) begin
      load = tx_mode & tx_full & module_enable &
             (((state == STM_IDLE) & master_go) | frame_end);      // RL16 RL19
    end else begin
      // Slave preloads so its first bit is ready before the first edge
      load = tx_mode & tx_full & module_enable & ~shift_loaded &
             (state == STM_IDLE);                                  // RL8 RL17
    end
    next_tx_full = data_wr_strobe | (tx_full & ~load);
  end

  // Two-flop synchronisers for every pin input
  always_ff @(posedge mclk) begin
    if (srst) begin
      sck_s1 <= 1'h0;
      sck_s2 <= 1'h0;
      sck_s3 <= 1'h0;
      ss_s1 <= 1'h1;
      ss_s2 <= 1'h1;
      mo_s1 <= 1'h0;
      mo_s2 <= 1'h0;
      mi_s1 <= 1'h0;
      mi_s2 <= 1'h0;
    end else begin
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;  // Edge detect compares stages two and three
      ss_s1 <= slave_select_n;
      ss_s2 <= ss_s1;
      mo_s1 <= mosi_in;
      mo_s2 <= mo_s1;
      mi_s1 <= miso_in;
      mi_s2 <= mi_s1;
    end
  end

  // Frame sequencing and edge counting
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= STM_IDLE;
      edge_cnt <= 5'h00;
    end else if (~module_enable) begin
      // Disable stops at once, even mid-frame
      state <= STM_IDLE;                                           // RL1
      edge_cnt <= 5'h00;
    end else if (~is_master & ss_s2) begin
      // Deselect aborts a partial slave frame
      state <= STM_IDLE;
      edge_cnt <= 5'h00;
    end else if (frame_end) begin
      edge_cnt <= 5'h00;
      if (is_master & (rx_mode | tx_full)) begin
        state <= STM_RUN;                                          // RL19 RL21
      end else begin
        state <= STM_IDLE;                                         // RL20 RL22
      end
    end else if (any_edge) begin
      edge_cnt <= edge_cnt + 5'h01;
      state <= STM_RUN;                                            // RL2 RL7 RL10
    end else if ((state == STM_IDLE) & master_go) begin
      state <= STM_RUN;                                            // RL1 RL16
    end
  end

  // Master baud divider and serial clock level
  always_ff @(posedge mclk) begin
    if (srst) begin
      div_cnt <= '0;
      sck_q <= 1'h0;
    end else if (~is_master | (state != STM_RUN)) begin
      div_cnt <= '0;
      sck_q <= clock_polarity;                                     // RL23
    end else if (tick) begin
      // Clock keeps toggling across frames when the next word is ready
      div_cnt <= '0;
      sck_q <= ~sck_q;                                             // RL19
    end else begin
      div_cnt <= div_cnt + `STM_DIV_W'(1);
    end
  end

  // Send buffer; a write during a load refills it, so it stays full
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_buf <= '0;
      tx_full <= 1'h0;
      transmit_empty_flag <= `STM_TE_RESET;
    end else begin
      if (data_wr_strobe) begin
        tx_buf <= data_wr;
      end
      tx_full <= next_tx_full;
      transmit_empty_flag <= ~next_tx_full;                        // RL14
    end
  end

  // Transmit shifter: parallel load then shift in the chosen order
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_shift <= '0;
      shift_loaded <= 1'h0;
    end else if (load) begin
      tx_shift <= tx_buf;                                          // RL5 RL14
      shift_loaded <= 1'h1;
    end else begin
      if (shift_edge & tx_mode) begin
        if (lsb_first_select) begin
          tx_shift <= {1'b0, tx_shift[FW-1:1]};                    // RL24
        end else begin
          tx_shift <= {tx_shift[FW-2:0], 1'b0};                    // RL24
        end
      end
      if (frame_end | ~module_enable) begin
        shift_loaded <= 1'h0;
      end
    end
  end

  // Receive shifter, fed on sampling edges
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_shift <= '0;
    end else if (sample_edge) begin
      rx_shift <= rx_full_word;                                    // RL6 RL11
    end
  end

  // Receive buffer, not-empty and overflow; a new word wins over a read
  always_ff @(posedge mclk) begin
    if (srst) begin
      data_rd <= '0;
      receive_not_empty_flag <= 1'h0;
      overflow_flag <= 1'h0;
      ovf_armed <= 1'h0;
    end else begin
      if (done_sample & rx_store &
          receive_not_empty_flag & ~data_rd_strobe) begin
        // Unread word kept, new word lost
        overflow_flag <= 1'h1;                                     // RL25
        ovf_armed <= 1'h0;
      end else begin
        if (done_sample & rx_store) begin
          data_rd <= rx_word;                                      // RL15
          receive_not_empty_flag <= 1'h1;                          // RL15
        end else if (data_rd_strobe) begin
          receive_not_empty_flag <= 1'h0;                          // RL3
        end
        // Overflow clears on a data read followed by a status read
        if (overflow_flag & data_rd_strobe) begin
          ovf_armed <= 1'h1;
        end else if (ovf_armed & status_rd_strobe) begin
          overflow_flag <= 1'h0;
          ovf_armed <= 1'h0;
        end
      end
    end
  end

  // Busy flag per mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_flag <= 1'h0;
    end else if (~module_enable) begin
      busy_flag <= 1'h0;
    end else if (is_master) begin
      if (one_wire_mode & ~one_wire_output_enable) begin
        // Master one-wire receive reports not busy while running
        busy_flag <= 1'h0;
      end else if (receive_only) begin
        busy_flag <= 1'h1;                                         // RL21
      end else if (frame_end) begin
        busy_flag <= tx_full;                                      // RL19 RL20
      end else begin
        busy_flag <= (state == STM_RUN) | master_go;
      end
    end else if (ss_s2 | frame_end) begin
      busy_flag <= 1'h0;                                           // RL20 RL22
    end else if (any_edge & (edge_cnt == 5'h01)) begin
      // Set on the second edge: low spans a full clock between words
      busy_flag <= 1'h1;                                           // RL22
    end
  end

  // Interrupt requests gated by their enables
  always_ff @(posedge mclk) begin
    if (srst) begin
      transmit_empty_irq <= 1'h0;
      receive_not_empty_irq <= 1'h0;
    end else begin
      transmit_empty_irq <= transmit_empty_flag & transmit_empty_irq_enable;         // RL14
      receive_not_empty_irq <= receive_not_empty_flag & receive_not_empty_irq_enable; // RL15
    end
  end

  // Registered pin drive; receive modes leave data pins undriven
  always_ff @(posedge mclk) begin
    if (srst) begin
      sck_out <= 1'h0;
      sck_oe_n <= 1'h1;
      mosi_out <= 1'h0;
      mosi_oe_n <= 1'h1;
      miso_out <= 1'h0;
      miso_oe_n <= 1'h1;
    end else begin
      sck_out <= sck_q;
      sck_oe_n <= ~(is_master & module_enable);
      mosi_out <= out_bit(tx_shift, lsb_first_select, frame_width_select);
      mosi_oe_n <= ~(is_master & module_enable & tx_mode);         // RL5 RL6
      miso_out <= out_bit(tx_shift, lsb_first_select, frame_width_select);
      miso_oe_n <= ~(~is_master & module_enable & ~ss_s2 & tx_mode); // RL10 RL11
    end
  end

endmodule : stm_spi_engine
`default_nettype wire
